// ### testbench/bci_bus_ctl_model.sv
// ****************************************
// bus controller model: sends command bytes
// ****************************************
module bci_bus_ctl_model (
  input wire logic aclk,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic remote_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    remote_enable = 1'b1;
  end
  task automatic send(input string s, input bit ren, input int gap);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge aclk);
      rx_byte <= s[i];
      rx_valid <= 1'b1;
      remote_enable <= ren;
      repeat (gap) begin
        @(posedge aclk);
        rx_valid <= 1'b0;
        rx_byte <= ~rx_byte;
      end
    end
    @(posedge aclk);
    rx_valid <= 1'b0;
    rx_byte <= ~rx_byte;
    remote_enable <= 1'b1;
  endtask
endmodule

// ### testbench/bci_cmd_monitor.sv
module bci_cmd_monitor (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] rx_byte,
  input wire rx_valid,
  input wire remote_enable,
  input wire device_clear,
  input wire [3:0] func_reg,
  input wire [3:0] range_reg,
  input wire autorange_reg,
  input wire zero_en_reg,
  input wire reading_ready_reg,
  input wire [16:0] trigger_delay_ms_reg,
  input wire memory_self_test_reg,
  input wire press_panel_button_reg,
  input wire bus_error_reg
);
  timeunit 1ns;
  timeprecision 1ns;
  wire x_taken = rx_valid && remote_enable && (rx_byte == 8'h58);
  wire cmd_evt = x_taken || device_clear || !aresetn;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_func_limit: assert property (func_reg <= 4'hD)
    else $error("function code above limit");
  chk_range_limit: assert property (range_reg <= 4'h8)
    else $error("range code above limit");
  chk_fixed_range: assert property (($changed(range_reg) && range_reg != 4'h0) |-> !autorange_reg)
    else $error("autorange kept on fixed range");
  chk_delay_limit: assert property (trigger_delay_ms_reg <= 17'h0EA60)
    else $error("delay above limit");
  chk_func_settle: assert property (($changed(func_reg) && !$past(device_clear)) |-> !reading_ready_reg)
    else $error("ready during function setup");
  chk_range_settle: assert property (($changed(range_reg) && !$past(device_clear)) |-> !reading_ready_reg)
    else $error("ready during range setup");
  chk_apply_on_x: assert property (($changed(func_reg) || $changed(range_reg) || $changed(zero_en_reg))
    |-> ($past(cmd_evt) || $past(cmd_evt, 2) || $past(cmd_evt, 3)))
    else $error("setting changed without execute");
  chk_ren_ignored: assert property ((rx_valid && !remote_enable && !device_clear) |=> bus_error_reg)
    else $error("bus error not flagged");
  chk_clear_default: assert property (device_clear
    |=> (func_reg == 4'h0 && range_reg == 4'h0 && autorange_reg && !zero_en_reg))
    else $error("clear did not restore defaults");
  chk_test_pulse: assert property (memory_self_test_reg |=> !memory_self_test_reg)
    else $error("self test pulse too long");
  chk_button_pulse: assert property (press_panel_button_reg |=> !press_panel_button_reg)
    else $error("button pulse too long");
endmodule
bind bci_command_interpreter bci_cmd_monitor i_mon (.aclk, .aresetn, .rx_byte, .rx_valid,
  .remote_enable, .device_clear, .func_reg, .range_reg, .autorange_reg, .zero_en_reg,
  .reading_ready_reg, .trigger_delay_ms_reg, .memory_self_test_reg,
  .press_panel_button_reg, .bus_error_reg);

// ### testbench/tb.sv
`include "bci_defines.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0, aresetn = 1'b0, device_clear = 1'b0;
  logic [31:0] meas_value = 32'h0, s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
  logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata, reading_reg;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] s_axi_wstrb = 4'hF, func_reg, range_reg;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] rx_byte, button_id_reg, bt_id = 8'h00;
  logic rx_valid, remote_enable, autorange_reg, zero_en_reg, reading_ready_reg;
  logic [2:0] send_status_word_reg;
  logic [16:0] trigger_delay_ms_reg;
  logic scanner_enabled_reg, memory_self_test_reg, press_panel_button_reg;
  logic show_text_message_reg, ref_junction_value_reg, smoothing_filter_on_reg;
  logic bus_error_reg, st_seen = 1'b0, bt_seen = 1'b0;
  logic [33:0] exp_q[$];
  int fails = 0, comparisons = 0;
  bci_bus_ctl_model i_ctl (.aclk, .rx_byte, .rx_valid, .remote_enable);
  bci_command_interpreter i_dut (.aclk, .aresetn, .rx_byte, .rx_valid, .remote_enable,
    .device_clear, .meas_value, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .func_reg, .range_reg,
    .autorange_reg, .zero_en_reg, .reading_ready_reg, .reading_reg,
    .send_status_word_reg, .scanner_enabled_reg, .trigger_delay_ms_reg,
    .memory_self_test_reg, .press_panel_button_reg, .button_id_reg,
    .show_text_message_reg, .ref_junction_value_reg, .smoothing_filter_on_reg,
    .bus_error_reg);
  always #20 aclk = ~aclk;
  // ****************************************
  // result watchers
  // ****************************************
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0) begin
      `CHK({s_axi_rresp, s_axi_rdata}, exp_q[0])
      void'(exp_q.pop_front());
    end
    if (memory_self_test_reg) st_seen <= 1'b1;
    if (press_panel_button_reg) bt_seen <= 1'b1;
    if (press_panel_button_reg) bt_id <= button_id_reg;
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic print_verdict();
    if (exp_q.size() != 0) fails++;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic bail(input int n);
    if (n >= 400) begin
      fails++;
      print_verdict();
    end
  endtask
  task automatic wait_ready();
    int n;
    for (n = 0; n < 400 && reading_ready_reg !== 1'b1; n++) @(posedge aclk);
    bail(n);
  endtask
  task automatic cmd(input string s);
    i_ctl.send(s, 1'b1, 0);
    repeat (4) @(posedge aclk);
    wait_ready();
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    s_axi_awaddr <= {24'h000000, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 400; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    bail(n);
    `CHK(s_axi_bresp, r)
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    exp_q.push_back(e);
    s_axi_araddr <= {24'h000000, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 400; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    bail(n);
    @(posedge aclk);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    int btn;
    void'($urandom(32'hC31D6546));
    btn = $urandom_range(99, 0);
    meas_value <= $urandom;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK(autorange_reg, 1'b1)
    axi_wr(`BCI_OFS_SETUP, 32'h2, 2'b00);
    axi_wr(`BCI_OFS_STATUS, 32'h1, 2'b10);
    axi_rd(`BCI_OFS_SETUP, {2'b00, 32'h2});
    axi_rd(8'h40, {2'b10, 32'h0});
    wait_ready();
    for (int f = 0; f < 14; f++) begin
      cmd($sformatf("F%0dX", f));
      `CHK(func_reg, f[3:0])
    end
    for (int r = 0; r < 9; r++) begin
      cmd($sformatf("R%0dX", r));
      `CHK(range_reg, r[3:0])
      `CHK(autorange_reg, r == 0)
    end
    cmd("F2Q1X");
    `CHK(func_reg, 4'hD)
    cmd("F14X");
    `CHK(func_reg, 4'hD)
    cmd("R9X");
    `CHK(range_reg, 4'h8)
    i_ctl.send("F3", 1'b1, 0);
    repeat (6) @(posedge aclk);
    `CHK(func_reg, 4'hD)
    cmd("X");
    `CHK(func_reg, 4'h3)
    cmd("X");
    `CHK(func_reg, 4'h3)
    `CHK(range_reg, 4'h8)
    cmd("Z1X");
    `CHK(zero_en_reg, 1'b1)
    axi_rd(`BCI_OFS_READING, {2'b00, 32'h0});
    cmd("V5X");
    cmd("Z2X");
    axi_rd(`BCI_OFS_READING, {2'b00, meas_value - 32'd5});
    cmd("Z0X");
    `CHK(zero_en_reg, 1'b0)
    axi_rd(`BCI_OFS_READING, {2'b00, meas_value});
    device_clear <= 1'b1;
    @(posedge aclk);
    device_clear <= 1'b0;
    repeat (3) @(posedge aclk);
    wait_ready();
    `CHK({func_reg, range_reg, autorange_reg}, 9'h001)
    axi_rd(`BCI_OFS_VALUE, {2'b00, 32'h0});
    cmd("Z2X");
    axi_rd(`BCI_OFS_READING, {2'b00, 32'h0});
    for (int u = 0; u < 8; u++) begin
      cmd($sformatf("U%0dX", u));
      `CHK(send_status_word_reg, u[2:0])
    end
    cmd("W60000X");
    `CHK(trigger_delay_ms_reg, 17'h0EA60)
    cmd("W60001X");
    `CHK(trigger_delay_ms_reg, 17'h0EA60)
    cmd($sformatf("A1N1O1J0H%0dX", btn));
    `CHK(smoothing_filter_on_reg, 1'b1)
    `CHK(scanner_enabled_reg, 1'b1)
    `CHK(ref_junction_value_reg, 1'b1)
    `CHK(st_seen, 1'b1)
    `CHK({bt_seen, bt_id}, {1'b1, btn[7:0]})
    cmd("N0O0X");
    `CHK({smoothing_filter_on_reg, ref_junction_value_reg}, 2'b00)
    cmd("DABCDEFGHIJKLMNX");
    `CHK(show_text_message_reg, 1'b1)
    axi_rd(`BCI_OFS_MSG0, {2'b00, 32'h44434241});
    axi_rd(`BCI_OFS_MSG3, {2'b00, 32'h00004E4D});
    cmd("DX");
    `CHK(show_text_message_reg, 1'b0)
    i_ctl.send("F1X", 1'b0, 2);
    repeat (4) @(posedge aclk);
    `CHK({bus_error_reg, func_reg}, 5'h10)
    cmd("X");
    `CHK(bus_error_reg, 1'b0)
    repeat (5) @(posedge aclk);
    print_verdict();
  end
endmodule

// ### verilog/bci_command_interpreter.v
// Overview of operation
// - execute character X makes the device carry out the buffered commands.
// - command bytes without X are buffered and left unapplied, except the supplied value, stored as soon as its argument ends.
// - on X, buffered commands apply only if every command was valid.
// - a lone X changes no mode; device remains listening.
// - function codes 0..13 select the measurement function.
// - after a function change, ready only once front end setup completes.
// - power-up and device clear restore function, range and zero defaults.
// - range codes 0..8; code 0 is autorange or first sensor type.
// - a fixed range code cancels autoranging.
// - after a range change, ready only once range setup completes.
// - zero 0 disables offset; 1 captures input as stored baseline.
// - zero 2 uses supplied value as baseline; reading is input minus it.
// - zero 2 without a supplied value acts as zero 1.
// - power-up and device clear reset the supplied value to zero.
// - status-output codes 0..7 select which word is transmitted.
// - delay argument accepted from 0 to 60000 ms.
// - message of up to 14 characters; bare display command cancels it.
// - self-test runs program, working and nonvolatile memory tests.
// - panel-button command acts as pressing button n.
// - junction code 0 measures; code 1 uses supplied value.
// - smoothing filter code 0 off, code 1 on.
// - bytes arriving without remote enable are ignored and flag a bus error.
`include "bci_defines.vh"
module bci_command_interpreter (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] rx_byte,
  input wire rx_valid,
  input wire remote_enable,
  input wire device_clear,
  input wire [31:0] meas_value,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [3:0] func_reg,
  output reg [3:0] range_reg,
  output reg autorange_reg,
  output reg zero_en_reg,
  output reg reading_ready_reg,
  output reg [31:0] reading_reg,
  output reg [2:0] send_status_word_reg,
  output reg scanner_enabled_reg,
  output reg [16:0] trigger_delay_ms_reg,
  output reg memory_self_test_reg,
  output reg press_panel_button_reg,
  output reg [7:0] button_id_reg,
  output reg show_text_message_reg,
  output reg ref_junction_value_reg,
  output reg smoothing_filter_on_reg,
  output reg bus_error_reg
);
  // ****************************************
  // parser states
  // ****************************************
  localparam ST_IDLE = 2'b00;
  localparam ST_ARG = 2'b01;
  localparam ST_MSG = 2'b10;
  localparam [15:0] SETUP_CYC = `BCI_SETUP_CYC;

  function is_digit;
    input [7:0] c;
    begin
      is_digit = (c >= 8'h30) && (c <= 8'h39);
    end
  endfunction

  function [31:0] acc10;
    input [31:0] a;
    input [7:0] c;
    begin
      acc10 = (a << 3) + (a << 1) + {28'h0000000, c[3:0]};
    end
  endfunction

  reg [1:0] state_reg;
  reg [7:0] letter_reg;
  reg [31:0] arg_reg;
  reg have_digit_reg;
  reg neg_reg;
  reg invalid_reg;
  reg any_pending_reg;
  reg [7:0] msg_mem [0:13];
  reg [7:0] pmsg [0:13];
  reg [3:0] msg_cnt_reg;
  // pending shadow copies
  reg pf_set, pr_set, pz_set, pu_set, pa_set, pw_set, pj_set, ph_set, pd_set;
  reg po_set, pn_set;
  reg [3:0] pf, pr, pz;
  reg [2:0] pu;
  reg pa, po, pn, pd_cancel;
  reg [16:0] pw;
  reg [7:0] ph;
  reg [31:0] value_reg;
  reg value_known_reg;
  reg [31:0] baseline_reg;
  reg cmd_error_reg;
  reg [15:0] setup_cnt_reg;
  reg [15:0] setup_len_reg;
  integer i;

  wire rx_ok = rx_valid && remote_enable;
  wire is_letter = (rx_byte >= 8'h41) && (rx_byte <= 8'h5A);
  wire in_arg_end = rx_ok && (state_reg == ST_ARG) && !is_digit(rx_byte)
                    && !(letter_reg == 8'h56 && (rx_byte == 8'h2D || rx_byte == 8'h2B));
  wire [31:0] argv = neg_reg ? (32'h00000000 - arg_reg) : arg_reg;
  // argument closed by the execute byte applies in the same cycle
  wire close_bad = in_arg_end && letter_reg_bad(letter_reg, arg_reg, have_digit_reg);
  wire cl_f = in_arg_end && (letter_reg == 8'h46);
  wire cl_r = in_arg_end && (letter_reg == 8'h52);
  wire cl_z = in_arg_end && (letter_reg == 8'h5A);
  wire cl_u = in_arg_end && (letter_reg == 8'h55);
  wire cl_a = in_arg_end && (letter_reg == 8'h41);
  wire cl_w = in_arg_end && (letter_reg == 8'h57);
  wire cl_j = in_arg_end && (letter_reg == 8'h4A);
  wire cl_h = in_arg_end && (letter_reg == 8'h48);
  wire cl_o = in_arg_end && (letter_reg == 8'h4F);
  wire cl_n = in_arg_end && (letter_reg == 8'h4E);
  wire [3:0] nf = cl_f ? arg_reg[3:0] : pf;
  wire [3:0] nr = cl_r ? arg_reg[3:0] : pr;
  wire [3:0] nz = cl_z ? arg_reg[3:0] : pz;

  // ****************************************
  // parser and executor
  // ****************************************
  always @(posedge aclk) begin
    memory_self_test_reg <= 1'b0;
    press_panel_button_reg <= 1'b0;
    if (!aresetn || device_clear) begin
      state_reg <= ST_IDLE;
      letter_reg <= 8'h00;
      arg_reg <= 32'h00000000;
      have_digit_reg <= 1'b0;
      neg_reg <= 1'b0;
      invalid_reg <= 1'b0;
      any_pending_reg <= 1'b0;
      {pf_set, pr_set, pz_set, pu_set, pa_set, pw_set} <= 6'h00;
      {pj_set, ph_set, pd_set, po_set, pn_set} <= 5'h00;
      pf <= 4'h0; pr <= 4'h0; pz <= 4'h0; pu <= 3'h0;
      pa <= 1'b0; po <= 1'b0; pn <= 1'b0; pd_cancel <= 1'b0;
      pw <= 17'h00000; ph <= 8'h00; msg_cnt_reg <= 4'h0;
      // defaults restore
      // restore defaults
      func_reg <= `BCI_FUNC_RST;
      range_reg <= `BCI_RANGE_RST;
      autorange_reg <= 1'b1;
      zero_en_reg <= 1'b0;
      baseline_reg <= 32'h00000000;
      value_reg <= 32'h00000000;
      value_known_reg <= 1'b0;
      send_status_word_reg <= 3'h0;
      scanner_enabled_reg <= 1'b0;
      trigger_delay_ms_reg <= 17'h00000;
      button_id_reg <= 8'h00;
      show_text_message_reg <= 1'b0;
      ref_junction_value_reg <= 1'b0;
      smoothing_filter_on_reg <= 1'b0;
      cmd_error_reg <= 1'b0;
      reading_ready_reg <= 1'b0;
      setup_cnt_reg <= SETUP_CYC;
      for (i = 0; i < `BCI_MSG_LEN; i = i + 1) begin
        msg_mem[i] <= 8'h20;
        pmsg[i] <= 8'h20;
      end
    end else begin
      if (setup_cnt_reg != 16'h0000) begin
        setup_cnt_reg <= setup_cnt_reg - 16'h0001;
        reading_ready_reg <= 1'b0;
      end else begin
        reading_ready_reg <= 1'b1;
      end
      // close out a numeric command when its argument ends
      // hold until execute; V stores its value at once
      if (in_arg_end) begin
        any_pending_reg <= 1'b1;
        state_reg <= ST_IDLE;
        case (letter_reg)
          8'h46: begin
            if (!have_digit_reg || arg_reg > {28'h0, `BCI_FUNC_MAX}) invalid_reg <= 1'b1;
            pf <= arg_reg[3:0]; pf_set <= 1'b1;
          end
          8'h52: begin
            if (!have_digit_reg || arg_reg > {28'h0, `BCI_RANGE_MAX}) invalid_reg <= 1'b1;
            pr <= arg_reg[3:0]; pr_set <= 1'b1;
          end
          8'h5A: begin
            if (!have_digit_reg || arg_reg > {28'h0, `BCI_ZERO_MAX}) invalid_reg <= 1'b1;
            pz <= arg_reg[3:0]; pz_set <= 1'b1;
          end
          8'h55: begin
            if (!have_digit_reg || arg_reg > {28'h0, `BCI_USEL_MAX}) invalid_reg <= 1'b1;
            pu <= arg_reg[2:0]; pu_set <= 1'b1;
          end
          8'h41: begin
            if (!have_digit_reg || arg_reg > 32'h00000001) invalid_reg <= 1'b1;
            pa <= arg_reg[0]; pa_set <= 1'b1;
          end
          8'h57: begin
            if (!have_digit_reg || arg_reg > {15'h0, `BCI_DELAY_MAX}) invalid_reg <= 1'b1;
            pw <= arg_reg[16:0]; pw_set <= 1'b1;
          end
          8'h4A: begin
            if (!have_digit_reg || arg_reg != 32'h00000000) invalid_reg <= 1'b1;
            pj_set <= 1'b1;
          end
          8'h48: begin
            if (!have_digit_reg || arg_reg > 32'h000000FF) invalid_reg <= 1'b1;
            ph <= arg_reg[7:0]; ph_set <= 1'b1;
          end
          8'h4F: begin
            if (!have_digit_reg || arg_reg > 32'h00000001) invalid_reg <= 1'b1;
            po <= arg_reg[0]; po_set <= 1'b1;
          end
          8'h4E: begin
            if (!have_digit_reg || arg_reg > 32'h00000001) invalid_reg <= 1'b1;
            pn <= arg_reg[0]; pn_set <= 1'b1;
          end
          8'h56: begin
            if (!have_digit_reg) begin
              invalid_reg <= 1'b1;
            end else begin
              value_reg <= argv;
              value_known_reg <= 1'b1;
            end
          end
          default: invalid_reg <= 1'b1;
        endcase
      end
      if (rx_ok) begin
        case (state_reg)
          ST_MSG: begin
            if (rx_byte == 8'h58) begin
              pd_cancel <= (msg_cnt_reg == 4'h0);
            end else if (msg_cnt_reg < `BCI_MSG_LEN) begin
              pmsg[msg_cnt_reg] <= rx_byte;
              msg_cnt_reg <= msg_cnt_reg + 4'h1;
            end else begin
              invalid_reg <= 1'b1;
            end
          end
          ST_ARG: begin
            if (is_digit(rx_byte)) begin
              arg_reg <= acc10(arg_reg, rx_byte);
              have_digit_reg <= 1'b1;
            end else if (!in_arg_end) begin
              neg_reg <= (rx_byte == 8'h2D);
            end
          end
          default: begin
          end
        endcase
        if ((state_reg != ST_ARG && state_reg != ST_MSG) || in_arg_end) begin
          if (rx_byte == 8'h58) begin
          end else if (rx_byte == 8'h44) begin
            state_reg <= ST_MSG;
            pd_set <= 1'b1;
            msg_cnt_reg <= 4'h0;
            any_pending_reg <= 1'b1;
          end else if (is_letter) begin
            state_reg <= ST_ARG;
            letter_reg <= rx_byte;
            arg_reg <= 32'h00000000;
            have_digit_reg <= 1'b0;
            neg_reg <= 1'b0;
          end else if (rx_byte != 8'h20) begin
            invalid_reg <= 1'b1;
          end
        end
        if (rx_byte == 8'h58) begin
          state_reg <= ST_IDLE;
          invalid_reg <= 1'b0;
          any_pending_reg <= 1'b0;
          {pf_set, pr_set, pz_set, pu_set, pa_set, pw_set} <= 6'h00;
          {pj_set, ph_set, pd_set, po_set, pn_set} <= 5'h00;
          cmd_error_reg <= invalid_reg || close_bad;
          if (!invalid_reg && !close_bad) begin
            if (pf_set || cl_f) begin
              func_reg <= nf;
              setup_cnt_reg <= setup_len_reg;
              reading_ready_reg <= 1'b0;
            end
            if (pr_set || cl_r) begin
              range_reg <= nr;
              autorange_reg <= (nr == 4'h0);
              setup_cnt_reg <= setup_len_reg;
              reading_ready_reg <= 1'b0;
            end
            if (pz_set || cl_z) begin
              zero_en_reg <= (nz != 4'h0);
              if (nz == 4'h2 && value_known_reg) baseline_reg <= value_reg;
              else if (nz != 4'h0) baseline_reg <= meas_value;
            end
            if (pu_set || cl_u) send_status_word_reg <= cl_u ? arg_reg[2:0] : pu;
            if (pa_set || cl_a) scanner_enabled_reg <= cl_a ? arg_reg[0] : pa;
            if (pw_set || cl_w) trigger_delay_ms_reg <= cl_w ? arg_reg[16:0] : pw;
            if (pj_set || cl_j) memory_self_test_reg <= 1'b1;
            if (ph_set || cl_h) begin
              press_panel_button_reg <= 1'b1;
              button_id_reg <= cl_h ? arg_reg[7:0] : ph;
            end
            if (pd_set) begin
              show_text_message_reg <= !(state_reg == ST_MSG ? msg_cnt_reg == 4'h0
                                         : pd_cancel);
              for (i = 0; i < `BCI_MSG_LEN; i = i + 1) begin
                msg_mem[i] <= pmsg[i];
              end
            end
            if (po_set || cl_o) ref_junction_value_reg <= cl_o ? arg_reg[0] : po;
            if (pn_set || cl_n) smoothing_filter_on_reg <= cl_n ? arg_reg[0] : pn;
          end
        end
      end
    end
  end

  // an argument closed by X itself must be checked in the same cycle
  function letter_reg_bad;
    input [7:0] l;
    input [31:0] a;
    input hd;
    begin
      case (l)
        8'h46: letter_reg_bad = !hd || a > 32'h0000000D;
        8'h52: letter_reg_bad = !hd || a > 32'h00000008;
        8'h5A: letter_reg_bad = !hd || a > 32'h00000002;
        8'h55: letter_reg_bad = !hd || a > 32'h00000007;
        8'h41, 8'h4F, 8'h4E: letter_reg_bad = !hd || a > 32'h00000001;
        8'h57: letter_reg_bad = !hd || a > 32'h0000EA60;
        8'h4A: letter_reg_bad = !hd || a != 32'h00000000;
        8'h48: letter_reg_bad = !hd || a > 32'h000000FF;
        8'h56: letter_reg_bad = !hd;
        default: letter_reg_bad = 1'b1;
      endcase
    end
  endfunction

  // ****************************************
  // bus error and reading path
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn || device_clear) begin
      bus_error_reg <= 1'b0;
      reading_reg <= 32'h00000000;
    end else begin
      if (rx_valid && !remote_enable) bus_error_reg <= 1'b1;
      else if (rx_ok && rx_byte == 8'h58) bus_error_reg <= 1'b0;
      reading_reg <= zero_en_reg ? (meas_value - baseline_reg) : meas_value;
    end
  end

  // ****************************************
  // axi4-lite slave
  // ****************************************
  wire [7:0] waddr = s_axi_awaddr[7:0];
  wire [7:0] raddr = s_axi_araddr[7:0];
  wire [3:0] midx = {raddr[3:2], 2'b00};
  reg [31:0] rd_mux;
  reg rd_ok;

  always @* begin
    rd_ok = 1'b1;
    rd_mux = 32'h00000000;
    case (raddr)
      `BCI_OFS_STATUS: begin
        rd_mux[`BCI_ST_FUNC_LSB +: 4] = func_reg;
        rd_mux[`BCI_ST_RANGE_LSB +: 4] = range_reg;
        rd_mux[`BCI_ST_AUTO] = autorange_reg;
        rd_mux[`BCI_ST_ZERO] = zero_en_reg;
        rd_mux[`BCI_ST_READY] = reading_ready_reg;
        rd_mux[`BCI_ST_BUSERR] = bus_error_reg;
        rd_mux[`BCI_ST_CMDERR] = cmd_error_reg;
        rd_mux[`BCI_ST_MSGMODE] = show_text_message_reg;
        rd_mux[`BCI_ST_SCAN] = scanner_enabled_reg;
        rd_mux[`BCI_ST_SMOOTH] = smoothing_filter_on_reg;
        rd_mux[`BCI_ST_REFJ] = ref_junction_value_reg;
        rd_mux[`BCI_ST_VALKNOWN] = value_known_reg;
        rd_mux[`BCI_ST_PENDING] = any_pending_reg;
      end
      `BCI_OFS_READING: rd_mux = reading_reg;
      `BCI_OFS_BASELINE: rd_mux = baseline_reg;
      `BCI_OFS_VALUE: rd_mux = value_reg;
      `BCI_OFS_SETTINGS: rd_mux = {4'h0, button_id_reg, send_status_word_reg, trigger_delay_ms_reg};
      `BCI_OFS_SETUP: rd_mux = {16'h0000, setup_len_reg};
      8'h20, 8'h24, 8'h28: rd_mux = {msg_mem[midx + 4'h3], msg_mem[midx + 4'h2],
                                     msg_mem[midx + 4'h1], msg_mem[midx]};
      `BCI_OFS_MSG3: rd_mux = {16'h0000, msg_mem[13], msg_mem[12]};
      default: rd_ok = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h00000000;
      setup_len_reg <= SETUP_CYC;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
      if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (waddr == `BCI_OFS_SETUP) ? 2'b00 : 2'b10;
        if (waddr == `BCI_OFS_SETUP) begin
          if (s_axi_wstrb[0]) setup_len_reg[7:0] <= s_axi_wdata[7:0];
          if (s_axi_wstrb[1]) setup_len_reg[15:8] <= s_axi_wdata[15:8];
        end
      end
      if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
      end
    end
  end
endmodule

// ### verilog/bci_defines.vh
`ifndef BCI_DEFINES_VH
`define BCI_DEFINES_VH
// ****************************************
// register byte offsets
// ****************************************
`define BCI_OFS_STATUS 8'h00
`define BCI_OFS_READING 8'h04
`define BCI_OFS_BASELINE 8'h08
`define BCI_OFS_VALUE 8'h0C
`define BCI_OFS_SETTINGS 8'h10
`define BCI_OFS_SETUP 8'h14
`define BCI_OFS_MSG0 8'h20
`define BCI_OFS_MSG3 8'h2C
// ****************************************
// status field positions
// ****************************************
`define BCI_ST_FUNC_LSB 0
`define BCI_ST_RANGE_LSB 4
`define BCI_ST_AUTO 8
`define BCI_ST_ZERO 9
`define BCI_ST_READY 10
`define BCI_ST_BUSERR 11
`define BCI_ST_CMDERR 12
`define BCI_ST_MSGMODE 13
`define BCI_ST_SCAN 14
`define BCI_ST_SMOOTH 15
`define BCI_ST_REFJ 16
`define BCI_ST_VALKNOWN 17
`define BCI_ST_PENDING 18
// ****************************************
// limits and reset values
// ****************************************
`define BCI_FUNC_MAX 4'hD
`define BCI_RANGE_MAX 4'h8
`define BCI_ZERO_MAX 4'h2
`define BCI_USEL_MAX 4'h7
`define BCI_DELAY_MAX 17'h0EA60
`define BCI_MSG_LEN 14
`define BCI_FUNC_RST 4'h0
`define BCI_RANGE_RST 4'h0
// ****************************************
// timing
// ****************************************
`define BCI_CLK_MHZ 25
`define BCI_SETUP_US 10
`define BCI_SETUP_CYC ((`BCI_SETUP_US) * (`BCI_CLK_MHZ))
`endif
